/* bench/subtract_sfr_read_halt_ops_properties.sv */
// Purpose: port-level checks of the execute block
// Assumes: single clock, asynchronous active-low reset
// Notes: command word sits at byte address 0
`timescale 1ns/1ps
module subtract_sfr_read_halt_ops_chk (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic i_hsel,
   input wire logic [11:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic i_hready,
   input wire logic i_wake,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire logic o_watchdog_clear,
   input wire logic o_halted,
   input wire logic [7:0] o_acc
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   sequence take_cmd;
      i_hsel && i_hready && i_htrans[1] && i_hwrite && i_haddr == 12'h000 && o_hreadyout;
   endsequence
   sequence take_rd;
      i_hsel && i_hready && i_htrans[1] && !i_hwrite && o_hreadyout;
   endsequence
   chk_resp_okay: assert property (o_hresp == 1'b0)
      else $error("response not okay");
   chk_cmd_cycle: assert property (take_cmd |=> !o_hreadyout [*3] ##1 o_hreadyout)
      else $error("command length wrong");
   chk_read_cycle: assert property (take_rd |=> !o_hreadyout [*2] ##1 o_hreadyout)
      else $error("read length wrong");
   // o_acc lags the accumulator by one clock, so the busy cycle lies two samples back
   chk_acc_quiet: assert property ($changed(o_acc) |-> !$past(o_hreadyout, 2))
      else $error("accumulator moved outside a transfer");
   chk_clear_pulse: assert property (o_watchdog_clear |=> !o_watchdog_clear)
      else $error("watchdog clear too long");
   chk_clear_done: assert property (o_watchdog_clear |-> o_hreadyout && !$past(o_hreadyout))
      else $error("watchdog clear off its cycle");
   chk_clear_halts: assert property (o_watchdog_clear |-> ##[0:1] o_halted)
      else $error("halt not entered");
   chk_halt_holds: assert property (o_halted && !i_wake && !$past(i_wake) |=> o_halted)
      else $error("halt dropped without wake");
   chk_wake_exit: assert property (o_halted && i_wake |-> ##[1:3] !o_halted)
      else $error("wake ignored");
endmodule
bind subtract_sfr_read_halt_ops subtract_sfr_read_halt_ops_chk u_chk (.i_clk_sys, .i_nrst,
   .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hready, .i_wake, .o_hreadyout, .o_hresp,
   .o_watchdog_clear, .o_halted, .o_acc);

/* bench/test_subtract_sfr_read_halt_ops.sv */
// Purpose: directed bench over the register bus
// Assumes: bus hready is the slave's own hreadyout
// Notes: expected flags worked by hand from the subtract rules
`timescale 1ns/1ps
module test_subtract_sfr_read_halt_ops;
   logic i_clk_sys, i_nrst, i_hsel, i_hwrite, i_wake;
   logic [11:0] i_haddr;
   logic [1:0] i_htrans;
   logic [2:0] i_hsize;
   logic [31:0] i_hwdata, o_hrdata;
   logic o_hreadyout, o_hresp, o_watchdog_clear, o_halted;
   logic [7:0] o_acc;
   int n_fail, total_checks, n_clear;
   subtract_sfr_read_halt_ops dut (.i_clk_sys, .i_nrst, .i_hsel, .i_haddr, .i_htrans,
      .i_hwrite, .i_hsize, .i_hwdata, .i_hready(o_hreadyout), .i_wake, .o_hrdata,
      .o_hreadyout, .o_hresp, .o_watchdog_clear, .o_halted, .o_acc);
   initial begin
      i_clk_sys = 1'b0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) if (o_watchdog_clear === 1'b1) n_clear++;
   task tally_and_finish;
      if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // bounded wait for the slave to accept or answer
   task wait_ready;
      int k;
      k = 0;
      @(posedge i_clk_sys);
      while (o_hreadyout !== 1'b1) begin
         if (k == 200) begin
            n_fail++;
            tally_and_finish;
         end
         k++;
         @(posedge i_clk_sys);
      end
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      i_hsel <= 1'b1;
      i_haddr <= a;
      i_htrans <= 2'h2;
      i_hwrite <= w;
      wait_ready;
      i_hsel <= 1'b0;
      i_htrans <= 2'h0;
      i_hwdata <= d;
      wait_ready;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      check(o_hrdata, exp);
   endtask
   initial begin
      {i_nrst, i_hsel, i_hwrite, i_wake, i_haddr, i_htrans, i_hwdata} = '0;
      i_hsize = 3'h2;
      n_fail = 0;
      total_checks = 0;
      n_clear = 0;
      repeat (8) @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      @(posedge i_clk_sys);
      rd(12'h008, 32'h18);
      wr(12'h20C, 32'h05);
      wr(12'h004, 32'h06);
      wr(12'h000, 32'h0305);
      rd(12'h20C, 32'hFF);
      rd(12'h004, 32'h06);
      rd(12'h008, 32'h18);
      rd(12'h00C, 32'hFF);
      wr(12'h3FC, 32'h06);
      wr(12'h000, 32'h7F01);
      rd(12'h004, 32'h00);
      rd(12'h3FC, 32'h06);
      rd(12'h008, 32'h1F);
      wr(12'h004, 32'h01);
      // destination bit set on purpose: it must be ignored here
      wr(12'h000, 32'hFF06);
      rd(12'h004, 32'hFE);
      rd(12'h008, 32'h1B);
      wr(12'h17C, 32'h5A);
      wr(12'h000, 32'h1F00);
      rd(12'h004, 32'h5A);
      rd(12'h008, 32'h1B);
      check(o_acc, 32'h5A);
      wr(12'h020, 32'hFFFFFFFF);
      rd(12'h020, 32'h0);
      check(n_clear, 32'h0);
      wr(12'h000, 32'h0003);
      rd(12'h008, 32'h33);
      check(n_clear, 32'h1);
      check(o_halted, 32'h1);
      i_wake <= 1'b1;
      @(posedge i_clk_sys);
      i_wake <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
      check(o_halted, 32'h0);
      rd(12'h008, 32'h13);
      tally_and_finish;
   end
endmodule

/* src/byte_ram.sv */
// Purpose: small byte memory with registered read data
// Assumes: one write port, one read port, same clock
// Notes: contents are not reset; read data is registered
`timescale 1ns/1ps
module byte_ram #(
   parameter int DEPTH = 128,
   parameter int AW = 7
) (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [7:0] i_wdata,
   input wire logic [AW-1:0] i_raddr,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [DEPTH];
   always_ff @(posedge i_clk_sys) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= mem[i_raddr];
      end
   end
endmodule

/* src/sub_sfr_consts.svh */
// Purpose: constants for the subtract / special-page read / halt-entry execute block
// Assumes: byte addresses on AHB-Lite, one 32-bit word per register
// Notes: register offsets, field positions and the accumulator, flag, TO and PD reset values live here
`ifndef SUB_SFR_CONSTS_SVH
`define SUB_SFR_CONSTS_SVH
`define OFF_CMD        8'h00
`define OFF_ACC        8'h04
`define OFF_STATUS     8'h08
`define OFF_RESULT     8'h0C
`define OFF_SPR_WIN    8'h10
`define CMD_OP_LSB     0
`define CMD_OP_MSB     1
`define CMD_DEST_BIT   2
`define CMD_OPND_LSB   8
`define CMD_OPND_MSB   15
`define ST_C_BIT       0
`define ST_DC_BIT      1
`define ST_Z_BIT       2
`define ST_PD_N_BIT    3
`define ST_TO_N_BIT    4
`define ST_HALT_BIT    5
`define ACC_RST        8'h00
`define FLAGS_RST      3'h0
`define TO_N_RST       1'b1
`define PD_N_RST       1'b1
`define SPR_DEPTH      32
`define DREG_DEPTH     128
`endif

/* src/sub_sfr_pkg.sv */
// Purpose: types for the execute block
// Assumes: nothing
// Notes: opcode codes are the values software writes into the command field
package sub_sfr_pkg;
   typedef enum logic [1:0] {
      op_read_special_page_reg = 2'b00,
      op_subtract_register_op = 2'b01,
      op_subtract_immediate_op = 2'b10,
      op_sleep_entry = 2'b11
   } op_type;
endpackage

/* src/subtract_sfr_read_halt_ops.sv */
// Purpose: execute four core instructions issued from AHB-Lite registers
// Assumes: one clock, core reset; watchdog and wake-up live outside
// Notes: special-page registers and data registers are AHB windows
`timescale 1ns/1ps
`include "sub_sfr_consts.svh"
module subtract_sfr_read_halt_ops (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic i_hsel,
   input wire logic [11:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic i_wake,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic o_watchdog_clear,
   output logic o_halted,
   output logic [7:0] o_acc
);
   // phases: idle, op execute (waits for ram read), bus read data
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_fetch = 2'b01,
      st_exec = 2'b10,
      st_rdata = 2'b11
   } ph_type;

   ph_type ph_q, ph_d;
   logic [11:0] addr_q;
   logic wr_q, rd_q;
   sub_sfr_pkg::op_type op_q;
   logic dest_q;
   logic [7:0] opnd_q;
   logic [7:0] acc_q;
   logic c_q, dc_q, z_q;
   logic to_n_q, pd_n_q, halt_q;
   logic [7:0] result_q;
   logic [31:0] hrdata_q;
   logic ready_q;

   function automatic logic [9:0] sub8(input logic [7:0] m, input logic [7:0] s);
      logic [4:0] lo;
      logic [8:0] full;
      lo = {1'b0, m[3:0]} + {1'b0, ~s[3:0]} + 5'h01;
      full = {1'b0, m} + {1'b0, ~s} + 9'h001;
      // {carry, digit carry, result}; carry is the inverted borrow
      sub8 = {full[8], lo[4], full[7:0]};
   endfunction

   wire addr_ph = i_hsel && i_hready && i_htrans[1];
   wire [11:0] a = addr_q;
   wire is_spr = a[11:8] == 4'h1;
   wire is_dreg = a[11:9] == 3'h1;
   wire bus_wr_spr = wr_q && is_spr && ph_q == st_idle && !ready_q;
   wire bus_wr_dreg = wr_q && is_dreg && ph_q == st_idle && !ready_q;
   wire cmd_wr = wr_q && a == {4'h0, `OFF_CMD} && ph_q == st_idle && !ready_q;
   wire [7:0] spr_rdata, dreg_rdata;
   wire [4:0] spr_raddr = (ph_q == st_idle) ? a[6:2] : opnd_q[4:0];
   wire [6:0] dreg_raddr = (ph_q == st_idle) ? a[8:2] : opnd_q[6:0];
   wire [7:0] minuend = (op_q == sub_sfr_pkg::op_subtract_immediate_op) ? opnd_q : dreg_rdata;
   wire [9:0] diff = sub8(minuend, acc_q);
   wire exec = ph_q == st_exec;
   wire is_sub = op_q == sub_sfr_pkg::op_subtract_register_op ||
      op_q == sub_sfr_pkg::op_subtract_immediate_op;
   wire wb_reg = exec && op_q == sub_sfr_pkg::op_subtract_register_op && dest_q;
   wire wb_acc = exec && (op_q == sub_sfr_pkg::op_read_special_page_reg ||
      op_q == sub_sfr_pkg::op_subtract_immediate_op ||
      (op_q == sub_sfr_pkg::op_subtract_register_op && !dest_q));
   wire [7:0] acc_src = (op_q == sub_sfr_pkg::op_read_special_page_reg) ? spr_rdata : diff[7:0];
   wire [7:0] status = {2'b00, halt_q, to_n_q, pd_n_q, z_q, dc_q, c_q};
   wire acc_wr_bus = wr_q && a == {4'h0, `OFF_ACC} && ph_q == st_idle && !ready_q;

   byte_ram #(.DEPTH(`SPR_DEPTH), .AW(5)) u_spr (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_we(bus_wr_spr),
      .i_waddr(a[6:2]),
      .i_wdata(i_hwdata[7:0]),
      .i_raddr(spr_raddr),
      .o_rdata(spr_rdata)
   );
   byte_ram #(.DEPTH(`DREG_DEPTH), .AW(7)) u_dreg (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_we(bus_wr_dreg || wb_reg),
      .i_waddr(wb_reg ? opnd_q[6:0] : a[8:2]),
      .i_wdata(wb_reg ? diff[7:0] : i_hwdata[7:0]),
      .i_raddr(dreg_raddr),
      .o_rdata(dreg_rdata)
   );

   // bus is held off while an operation runs so window writes cannot collide
   always_comb begin
      ph_d = ph_q;
      unique case (ph_q)
         st_idle: begin
            if (cmd_wr) begin
               ph_d = st_fetch;
            end else if (rd_q && !ready_q) begin
               ph_d = st_rdata;
            end
         end
         st_fetch: ph_d = st_exec;
         st_exec: ph_d = st_idle;
         st_rdata: ph_d = st_idle;
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         ph_q <= st_idle;
         addr_q <= 12'h000;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         ready_q <= 1'b1;
      end else begin
         ph_q <= ph_d;
         if (addr_ph && ready_q) begin
            addr_q <= i_haddr;
            wr_q <= i_hwrite;
            rd_q <= !i_hwrite;
            ready_q <= 1'b0;
         end else if (ph_d == st_idle && ph_q != st_idle) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            ready_q <= 1'b1;
         end else if (ph_q == st_idle && !ready_q && !cmd_wr && !rd_q) begin
            wr_q <= 1'b0;
            ready_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         op_q <= sub_sfr_pkg::op_read_special_page_reg;
         dest_q <= 1'b0;
         opnd_q <= 8'h00;
      end else if (cmd_wr) begin
         op_q <= sub_sfr_pkg::op_type'(i_hwdata[`CMD_OP_MSB:`CMD_OP_LSB]);
         dest_q <= i_hwdata[`CMD_DEST_BIT];
         opnd_q <= i_hwdata[`CMD_OPND_MSB:`CMD_OPND_LSB];
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         acc_q <= `ACC_RST;
         {z_q, dc_q, c_q} <= `FLAGS_RST;
         result_q <= 8'h00;
      end else begin
         if (wb_acc) begin
            acc_q <= acc_src;
         end else if (acc_wr_bus) begin
            acc_q <= i_hwdata[7:0];
         end
         if (exec && is_sub) begin
            c_q <= diff[9];
            dc_q <= diff[8];
            z_q <= diff[7:0] == 8'h00;
            result_q <= diff[7:0];
         end
      end
   end

   // halt holds until the outside wake level, already synchronous to this clock
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         to_n_q <= `TO_N_RST;
         pd_n_q <= `PD_N_RST;
         halt_q <= 1'b0;
      end else begin
         if (exec && op_q == sub_sfr_pkg::op_sleep_entry) begin
            to_n_q <= 1'b1;
            pd_n_q <= 1'b0;
            halt_q <= 1'b1;
         end else if (i_wake) begin
            halt_q <= 1'b0;
         end
      end
   end

   wire [31:0] rd_mux =
      (a == {4'h0, `OFF_ACC}) ? {24'h0, acc_q} :
      (a == {4'h0, `OFF_STATUS}) ? {24'h0, status} :
      (a == {4'h0, `OFF_RESULT}) ? {24'h0, result_q} :
      (a == {4'h0, `OFF_CMD}) ? {16'h0, opnd_q, 5'h00, dest_q, op_q} :
      is_spr ? {24'h0, spr_rdata} :
      is_dreg ? {24'h0, dreg_rdata} : 32'h0;

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         hrdata_q <= 32'h0;
      end else if (ph_q == st_rdata) begin
         hrdata_q <= rd_mux;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         o_hrdata <= 32'h0;
         o_watchdog_clear <= 1'b0;
         o_halted <= 1'b0;
         o_acc <= 8'h00;
      end else begin
         o_hreadyout <= (addr_ph && ready_q) ? 1'b0 :
            ((ph_d == st_idle && ph_q != st_idle) ||
             (ph_q == st_idle && !ready_q && !cmd_wr && !rd_q)) ? 1'b1 : o_hreadyout;
         o_hresp <= 1'b0;
         o_hrdata <= (ph_q == st_rdata) ? rd_mux : hrdata_q;
         o_watchdog_clear <= exec && op_q == sub_sfr_pkg::op_sleep_entry;
         o_halted <= halt_q;
         o_acc <= acc_q;
      end
   end
endmodule
